// >>> rtl/dcr_map.svh
// Constants of the DMA channel enable and request block
`ifndef DCR_MAP_SVH
`define DCR_MAP_SVH
`define DCR_NUM_CH 4
`define DCR_CNT_W 16
`define DCR_CNT_RST 16'h0000
`define DCR_FIFO_DEPTH 16
`define DCR_DATA_W 16
`endif

// >>> rtl/dcr_pkg.sv
// Types of the DMA channel enable and request block
`include "dcr_map.svh"
package dcr_pkg;
  typedef struct packed {
    logic [1:0] chan;
    logic [`DCR_CNT_W-1:0] count;
  } dcr_xfer_t;

  typedef struct packed {
    logic wr;
    logic [1:0] chan;
    logic enable;
    logic pending;
  } dcr_ctl_wr_t;

  typedef enum logic [1:0] {
    DCR_IDLE = 2'b00,
    DCR_MOVE = 2'b01,
    DCR_DONE = 2'b11
  } dcr_state_t;
endpackage

// >>> rtl/dcr_fifo.sv
// Parameterised valid/ready FIFO
`timescale 1ns/1ps
`default_nettype none
module dcr_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp, rp, next_wp, next_rp;
  logic [AW:0] cnt, next_cnt;
  logic push, pop;

  always_comb begin
    push = in_valid_i && (cnt != (AW+1)'(DEPTH));
    pop = (cnt != '0) && out_ready_i;
    next_wp = push ? wp + 1'b1 : wp;
    next_rp = pop ? rp + 1'b1 : rp;
    next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else if (ce_i) begin
      wp <= next_wp;
      rp <= next_rp;
      cnt <= next_cnt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (ce_i && push) begin
      mem[wp] <= in_data_i;
    end
  end

  assign in_ready_o = (cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt != '0);
  assign out_data_o = mem[rp];
endmodule
`default_nettype wire

// >>> rtl/dcr_top.sv
// Four-channel DMA enable, request and transfer counter logic
// Function
// R01: Four channels, each active when enabled
// R02: Writing one leaves pending bit unchanged
// R03: Writing zero clears the pending bit
// R04: Re-enable write must also write pending one
// R05: Read-modify-write of enable writes pending one
// R06: Enable rewrite restores loaded counter value
// R07: Each serviced transfer decrements counter once
// R08: Fixed priority, channel 0 highest
// R09: Request sets pending until granted or cleared
`timescale 1ns/1ps
`default_nettype none
`include "dcr_map.svh"
module dcr_top #(
  parameter int NUM_CH = `DCR_NUM_CH,
  parameter int CNT_W = `DCR_CNT_W,
  parameter int FIFO_DEPTH = `DCR_FIFO_DEPTH
) (
  // Clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // Channel control write
  input wire dcr_pkg::dcr_ctl_wr_t ctl_wr_i,
  input wire logic cnt_wr_i,
  input wire logic [1:0] cnt_chan_i,
  input wire logic [CNT_W-1:0] cnt_data_i,
  // Peripheral request pins
  input wire logic [NUM_CH-1:0] req_pin_i,
  // Status
  output logic [NUM_CH-1:0] enable_o,
  output logic [NUM_CH-1:0] pending_o,
  output logic [NUM_CH*CNT_W-1:0] count_o,
  // Transfer stream out
  output logic xfer_valid_o,
  input wire logic xfer_ready_i,
  output dcr_pkg::dcr_xfer_t xfer_o
);
  import dcr_pkg::*;

  // ************************************************************
  // Reset release and request synchronisers
  // ************************************************************
  logic [1:0] rst_sync;
  logic rst_n;
  logic [NUM_CH-1:0] req_s1, req_s2, req_s3, req_prev, next_req_prev;
  logic [NUM_CH-1:0] req_rise, req_agree;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      req_s1 <= '0;
      req_s2 <= '0;
      req_s3 <= '0;
      req_prev <= '0;
    end else if (ce_i) begin
      req_s1 <= req_pin_i;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
      req_prev <= next_req_prev;
    end
  end
  always_comb begin
    // Each pin settles on its own, a moving pin must not hide the others
    req_agree = ~(req_s2 ^ req_s3);
    next_req_prev = (req_agree & req_s3) | (~req_agree & req_prev);
    req_rise = req_agree & req_s3 & ~req_prev;
  end

  // ************************************************************
  // Channel state
  // ************************************************************
  logic [NUM_CH-1:0] enable, next_enable, pending, next_pending;
  logic [CNT_W-1:0] load [NUM_CH];
  logic [CNT_W-1:0] count [NUM_CH];
  logic [CNT_W-1:0] next_load [NUM_CH];
  logic [CNT_W-1:0] next_count [NUM_CH];
  logic [NUM_CH-1:0] grant;
  logic fifo_ready;
  dcr_state_t state, next_state;
  logic [1:0] cur_ch, next_cur_ch;
  dcr_xfer_t push_data;
  logic push_valid;

  // Lowest set bit wins
  function automatic logic [NUM_CH-1:0] pick_first(input logic [NUM_CH-1:0] v);
    logic [NUM_CH-1:0] r;
    r = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = '0;
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction

  function automatic logic [1:0] enc(input logic [NUM_CH-1:0] v);
    logic [1:0] r;
    r = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (v[i]) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction

  always_comb begin
    next_enable = enable;
    next_pending = pending;
    next_state = state;
    next_cur_ch = cur_ch;
    grant = '0;
    push_valid = 1'b0;
    push_data = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      next_load[i] = load[i];
      next_count[i] = count[i];
    end
    case (state)
      DCR_IDLE: begin
        // R08: fixed priority
        grant = pick_first(pending & enable);
        if (grant != '0 && fifo_ready) begin
          next_cur_ch = enc(grant);
          next_state = DCR_MOVE;
        end
      end
      DCR_MOVE: begin
        // R07: one decrement per transfer
        push_valid = 1'b1;
        push_data.chan = cur_ch;
        push_data.count = count[cur_ch];
        next_count[cur_ch] = count[cur_ch] - 1'b1;
        next_pending[cur_ch] = 1'b0;
        next_state = DCR_DONE;
      end
      DCR_DONE: begin
        next_state = DCR_IDLE;
      end
      default: begin
        next_state = DCR_IDLE;
      end
    endcase
    if (cnt_wr_i) begin
      next_load[cnt_chan_i] = cnt_data_i;
      next_count[cnt_chan_i] = cnt_data_i;
    end
    if (ctl_wr_i.wr) begin
      // R01: enable bit activates channel
      next_enable[ctl_wr_i.chan] = ctl_wr_i.enable;
      // R06: enable write restores loaded count value
      if (ctl_wr_i.enable) begin
        next_count[ctl_wr_i.chan] = next_load[ctl_wr_i.chan];
      end
      // R03: zero clears pending
      // R02: a one leaves it standing
      if (!ctl_wr_i.pending) begin
        next_pending[ctl_wr_i.chan] = 1'b0;
      end
    end
    // R09: request sets pending, wins over clear
    next_pending = next_pending | (req_rise & enable);
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      enable <= '0;
      pending <= '0;
      state <= DCR_IDLE;
      cur_ch <= 2'h0;
      for (int i = 0; i < NUM_CH; i++) begin
        load[i] <= `DCR_CNT_RST;
        count[i] <= `DCR_CNT_RST;
      end
    end else if (ce_i) begin
      enable <= next_enable;
      pending <= next_pending;
      state <= next_state;
      cur_ch <= next_cur_ch;
      for (int i = 0; i < NUM_CH; i++) begin
        load[i] <= next_load[i];
        count[i] <= next_count[i];
      end
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      enable_o <= '0;
      pending_o <= '0;
      count_o <= '0;
    end else if (ce_i) begin
      enable_o <= next_enable;
      pending_o <= next_pending;
      for (int i = 0; i < NUM_CH; i++) begin
        count_o[i*CNT_W +: CNT_W] <= next_count[i];
      end
    end
  end

  // ************************************************************
  // Transfer FIFO
  // ************************************************************
  logic fifo_valid;
  dcr_xfer_t fifo_data;
  logic out_full;
  logic pop;

  dcr_fifo #(.WIDTH($bits(dcr_xfer_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .ce_i(ce_i),
    .in_valid_i(push_valid),
    .in_ready_o(fifo_ready),
    .in_data_i(push_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(pop),
    .out_data_o(fifo_data)
  );

  // Output register stage, refilled when empty or being taken
  assign pop = fifo_valid && (!out_full || xfer_ready_i);
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      out_full <= 1'b0;
      xfer_o <= '0;
    end else if (ce_i) begin
      if (pop) begin
        out_full <= 1'b1;
        xfer_o <= fifo_data;
      end else if (xfer_ready_i) begin
        out_full <= 1'b0;
      end
    end
  end
  assign xfer_valid_o = out_full;
endmodule
`default_nettype wire

// >>> test/dcr_top_monitor.sv
// Port checker of the DMA channel block
`timescale 1ns/1ps
`default_nettype none
module dcr_top_monitor (
  // Inputs and outputs watched
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire dcr_pkg::dcr_ctl_wr_t ctl_wr_i,
  input wire logic cnt_wr_i,
  input wire logic [1:0] cnt_chan_i,
  input wire logic [15:0] cnt_data_i,
  input wire logic [3:0] req_pin_i,
  input wire logic [3:0] enable_o,
  input wire logic [3:0] pending_o,
  input wire logic [63:0] count_o
);
  import dcr_pkg::*;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  logic [2:0] q;
  logic [15:0] ld [4];
  wire [1:0] c = ctl_wr_i.chan;
  wire wr = ce_i && ctl_wr_i.wr;
  wire qt = q == 3'h7;
  wire [3:0] act = pending_o & enable_o;
  // Quiet time on request pins and last loaded counts
  always_ff @(posedge ref_clk_i) begin
    if (!arst_n_i) begin
      q <= 3'h0;
      ld <= '{default: 16'h0};
    end else begin
      q <= (req_pin_i != 4'h0) ? 3'h0 : q + {2'h0, !qt};
      if (cnt_wr_i && ce_i) ld[cnt_chan_i] <= cnt_data_i;
    end
  end
  a_enable_write: assert property (wr |=> enable_o[$past(c)] == $past(ctl_wr_i.enable))
    else $error("enable bit not written");
  a_one_keeps: assert property (wr && ctl_wr_i.pending && qt && !pending_o[c]
    |=> !pending_o[$past(c)])
    else $error("pending set by write");
  a_zero_clears: assert property (wr && !ctl_wr_i.pending && qt |=> !pending_o[$past(c)])
    else $error("pending not cleared");
  a_reload_count: assert property (wr && ctl_wr_i.enable && qt && !act[c] && !cnt_wr_i
    |=> count_o[16*$past(c)+:16] == $past(ld[c]))
    else $error("count not reloaded");
  a_count_step: assert property ($changed(count_o[15:0]) && !$past(cnt_wr_i) && !$past(wr)
    |-> count_o[15:0] == $past(count_o[15:0]) - 16'h1)
    else $error("count step not one");
  a_fixed_prio: assert property ($fell(pending_o[1]) && !$past(wr)
    |-> !$past(act[0], 2))
    else $error("channel 1 served before 0");
  a_req_sets: assert property (ce_i && $rose(req_pin_i[0]) && enable_o[0] && !wr
    |-> ##[1:8] pending_o[0])
    else $error("request not seen");
  c_reload: cover property (wr && ctl_wr_i.enable && act[c]);
  c_clear: cover property (wr && !ctl_wr_i.pending && pending_o[c]);
  c_step: cover property ($fell(pending_o[1]));
endmodule
bind dcr_top dcr_top_monitor mon_u (.ref_clk_i, .arst_n_i, .ce_i, .ctl_wr_i, .cnt_wr_i,
  .cnt_chan_i, .cnt_data_i, .req_pin_i, .enable_o, .pending_o, .count_o);
`default_nettype wire

// >>> test/dcr_sink.sv
// Stream sink that takes words every other cycle or stalls
`timescale 1ns/1ps
`default_nettype none
module dcr_sink (
  // Clock and test control
  input wire logic clk_i,
  input wire logic stall_i,
  // Stream in
  input wire logic valid_i,
  output logic ready_o,
  // Words taken so far
  output int taken_o
);
  logic ph = 1'b0;
  int taken = 0;
  always @(posedge clk_i) begin
    ph <= ~ph;
    if (valid_i && ready_o) taken <= taken + 1;
  end
  assign ready_o = !stall_i && ph;
  assign taken_o = taken;
endmodule
`default_nettype wire

// >>> test/dcr_top_tb_top.sv
// Self-checking bench of the DMA channel block
`timescale 1ns/1ps
`default_nettype none
module dcr_top_tb_top;
  import dcr_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic stall = 1'b0;
  logic ce = 1'b1;
  dcr_ctl_wr_t ctl = '0;
  logic cnt_wr = 1'b0;
  logic [1:0] cnt_ch = 2'h0;
  logic [15:0] cnt_d = 16'h0;
  logic [3:0] req = 4'h0;
  logic [3:0] en, pend;
  logic [63:0] cnt;
  logic vld, rdy;
  dcr_xfer_t xf;
  int taken, failures = 0, check_count = 0;
  // Rows: chan, enable, pending, expected enable bits
  logic [7:0] rows [5] = '{8'h31, 8'h63, 8'h93, 8'hfb, 8'h49};
  initial forever #20 clk = ~clk;
  dcr_top dut_u (.ref_clk_i(clk), .arst_n_i(rst_n), .ce_i(ce), .ctl_wr_i(ctl),
    .cnt_wr_i(cnt_wr), .cnt_chan_i(cnt_ch), .cnt_data_i(cnt_d), .req_pin_i(req),
    .enable_o(en), .pending_o(pend), .count_o(cnt), .xfer_valid_o(vld),
    .xfer_ready_i(rdy), .xfer_o(xf));
  dcr_sink sink_u (.clk_i(clk), .stall_i(stall), .valid_i(vld), .ready_o(rdy),
    .taken_o(taken));
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      failures++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_ctl(input logic [1:0] ch, input logic e, input logic p);
    ctl = '{1'b1, ch, e, p};
    tick(1);
    ctl.wr = 1'b0;
    tick(2);
  endtask
  task automatic pulse(input logic [3:0] m);
    req = m;
    tick(2);
    req = 4'h0;
    tick(10);
  endtask
  task automatic wait_taken(input int n);
    for (int i = 0; i < 400 && taken != n; i++) tick(1);
    check(taken == n, "stream stuck");
    if (taken != n) tally_and_finish();
  endtask
  initial begin
    tick(6);
    rst_n = 1'b1;
    check(en === 4'h0 && pend === 4'h0 && cnt === 64'h0 && vld === 1'b0, "reset");
    tick(3);
    foreach (rows[i]) begin
      wr_ctl(rows[i][7:6], rows[i][5], rows[i][4]);
      check(en === rows[i][3:0] && pend === 4'h0, "control write");
    end
    for (int i = 0; i < 4; i++) begin
      cnt_wr = 1'b1;
      cnt_ch = i[1:0];
      cnt_d = 16'h0010 + 16'(i);
      tick(1);
      cnt_wr = 1'b0;
      wr_ctl(i[1:0], 1'b1, 1'b1);
    end
    stall = 1'b1;
    pulse(4'hb);
    check(vld === 1'b1 && xf.chan === 2'h0 && xf.count === 16'h0010, "first grant");
    stall = 1'b0;
    wait_taken(3);
    check(cnt === {16'h0012, 16'h0012, 16'h0010, 16'h000f}, "counters");
    stall = 1'b1;
    repeat (20) pulse(4'h1);
    check(pend === 4'h1, "request lost while full");
    // rewrite of enable keeps pending with one
    wr_ctl(2'h0, 1'b1, 1'b1);
    check(pend === 4'h1 && cnt[15:0] === 16'h0010, "rewrite");
    wr_ctl(2'h0, 1'b1, 1'b0);
    check(pend === 4'h0, "clear");
    stall = 1'b0;
    wait_taken(20);
    tick(20);
    check(taken == 20 && vld === 1'b0 && cnt[15:0] === 16'h0010, "drain");
    // request and zero write on one edge, set wins
    req = 4'h1;
    tick(3);
    ctl = '{1'b1, 2'h0, 1'b1, 1'b0};
    tick(1);
    ctl.wr = 1'b0;
    req = 4'h0;
    check(pend === 4'h1, "clear beat request");
    wait_taken(21);
    check(xf.chan === 2'h0 && xf.count === 16'h0010, "late word");
    check(cnt[15:0] === 16'h000f && pend === 4'h0, "late count");
    // clock enable low freezes the write
    ce = 1'b0;
    wr_ctl(2'h1, 1'b0, 1'b0);
    check(en === 4'hf, "write taken while frozen");
    ce = 1'b1;
    tick(2);
    check(en === 4'hf && pend === 4'h0, "after freeze");
    tally_and_finish();
  end
endmodule
`default_nettype wire
